// *** rtl/dcr_cfg_pkg.sv ***
// Package of offsets, field positions and reset values for the decompressor config bank
package dcr_cfg_pkg;
    localparam int          DCR_ADDR_W        = 10;
    localparam int          DATA_W            = 32;
    localparam int          OFS_W             = 11;
    localparam logic [9:0]  DCR_PTR_ADDR      = 10'h014;
    localparam logic [9:0]  DCR_WIN_ADDR      = 10'h015;
    localparam logic [10:0] OFS_ORIGIN_FIRST  = 11'h000;
    localparam logic [10:0] OFS_ORIGIN_LAST   = 11'h003;
    localparam logic [10:0] OFS_REGION_0      = 11'h004;
    localparam logic [10:0] OFS_REGION_1      = 11'h005;
    localparam logic [10:0] OFS_CONFIG        = 11'h040;
    localparam logic [10:0] OFS_IDENTITY      = 11'h041;
    localparam logic [10:0] OFS_VERSION       = 11'h042;
    localparam logic [10:0] OFS_SYS_ERR_ADDR  = 11'h050;
    localparam logic [10:0] OFS_MEM_ERR_ADDR  = 11'h051;
    localparam logic [10:0] OFS_ERR_STATUS    = 11'h052;
    localparam logic [10:0] OFS_RAM_FIRST     = 11'h400;
    localparam int          RAM_DEPTH         = 1024;
    // Bit masks in little-endian numbering (big-endian bit n is LE bit 31-n)
    localparam logic [31:0] ORIGIN_MASK       = 32'h000007FF;
    localparam logic [31:0] REGION_MASK       = 32'hFFCF0001;
    localparam logic [31:0] CONFIG_MASK       = 32'h00003FF9;
    localparam int          REG_BASE_LSB      = 22;
    localparam int          REG_SIZE_LSB      = 16;
    localparam int          REG_EN_BIT        = 0;
    localparam int          CFG_DISABLE_BIT   = 0;
    localparam int          CFG_FLUSH_BIT     = 2;
    localparam int          CFG_SLEEP_EN_BIT  = 3;
    localparam int          CFG_DELAY_LSB     = 4;
    localparam logic [3:0]  SIZE_CODE_MIN     = 4'h5;
    localparam logic [31:0] RESET_WORD        = 32'h00000000;
    // Arbitrary neutral identity values
    localparam logic [31:0] IDENTITY_DEFAULT  = 32'h00001234;
    localparam logic [31:0] VERSION_DEFAULT   = 32'h00000001;
endpackage : dcr_cfg_pkg

// *** rtl/dcr_cfg_ram.sv ***
// Decode-table RAM behind the indirect data window
module dcr_cfg_ram #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic              mclk_i,
    input  wire logic              we_i,
    input  wire logic [AW-1:0]     addr_i,
    input  wire logic [31:0]       wdata_i,
    output logic      [31:0]       rdata_o
);
    // Refuse a depth that the address width cannot index exactly
    if (DEPTH != (1 << AW))
    begin : g_depth_check
        $error("dcr_cfg_ram: DEPTH must equal 2**AW");
    end
    logic [31:0] mem [DEPTH];
    // Contents are undefined after reset; software loads the table before use
    always_ff @(posedge mclk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : dcr_cfg_ram

// *** rtl/dcr_cfg_region.sv ***
// Address match for one decode region
module dcr_cfg_region (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [31:0] region_i,
    input  wire logic [31:0] addr_i,
    output logic             hit_o
);
    import dcr_cfg_pkg::*;
    logic [3:0]  size;
    logic [31:0] mask;
    assign size = region_i[REG_SIZE_LSB +: 4];
    // Code 5 = 4MB: upper 10 bits compared; each step drops one compared bit
    always_comb
    begin
        mask = 32'hFFC00000 << (size - SIZE_CODE_MIN);
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            hit_o <= 1'b0;
        end
        else
        begin
            hit_o <= region_i[REG_EN_BIT] && (size >= SIZE_CODE_MIN)
                     && (((addr_i ^ region_i) & mask) == 32'h00000000);
        end
    end
endmodule : dcr_cfg_region

// *** rtl/dcr_cfg_regs.sv ***
// Configuration register bank reached through a pointer/window pair on the DCR bus
// Contract
// - Only two DCR registers: pointer and data window reach everything else
// - Pointer selects internal register; window reads and writes it
// - Decode origins 0-3, regions 4-5, config 0x40, RAM 0x400-0x7FF
// - Identity 0x41 and version 0x42 are read-only
// - Error addresses 0x50, 0x51 read-only; status 0x52 clears on read
// - Index origin keeps big-endian bits 21:31, rest reserved
// - Each region definition claims an address space for the datapath
// - Region base in bits 0:9; bits 10:11 and 16:30 reserved
// - Size code 0101=4MB doubling to 1111=4GB; 0000-0100 reserved
// - Region bit 31 enables decoding of that region
// - Config bit 31 set disables decompression, ignoring page attribute
// - Sleep delay in bits 18:27, sleep allow in bit 28
// - Writing 1 to bit 29 flushes buffer; self-clears, reads 0
module dcr_cfg_regs #(
    parameter logic [31:0] IDENTITY = dcr_cfg_pkg::IDENTITY_DEFAULT,
    parameter logic [31:0] VERSION  = dcr_cfg_pkg::VERSION_DEFAULT
) (
    input  wire logic                              mclk_i,
    input  wire logic                              sys_rst_i,
    input  wire logic [dcr_cfg_pkg::DCR_ADDR_W-1:0] dcr_addr_i,
    input  wire logic                              dcr_read_i,
    input  wire logic                              dcr_write_i,
    input  wire logic [31:0]                       dcr_wdata_i,
    output logic      [31:0]                       dcr_rdata_o,
    output logic                                   dcr_ack_o,
    input  wire logic [31:0]                       fetch_addr_i,
    input  wire logic                              compressed_page_attribute_i,
    input  wire logic                              err_capture_i,
    input  wire logic [31:0]                       err_sys_addr_i,
    input  wire logic [31:0]                       err_mem_addr_i,
    input  wire logic [31:0]                       err_status_i,
    output logic      [31:0]                       index_origin_0_o,
    output logic      [31:0]                       index_origin_1_o,
    output logic      [31:0]                       index_origin_2_o,
    output logic      [31:0]                       index_origin_3_o,
    output logic      [1:0]                        region_hit_o,
    output logic                                   decompress_active_o,
    output logic                                   flush_output_buffer_o,
    output logic                                   sleep_allow_o,
    output logic      [9:0]                        sleep_delay_count_o
);
    import dcr_cfg_pkg::*;

    logic [31:0] indirect_address_pointer;
    logic [31:0] index_origin [4];
    logic [31:0] region_decode [2];
    logic [31:0] decompressor_configuration;
    logic [31:0] sysbus_error_address;
    logic [31:0] memside_error_address;
    logic [31:0] error_status;
    logic [31:0] ram_rdata;
    logic [31:0] next_rdata;
    logic [10:0] ofs;
    logic        ptr_sel;
    logic        win_sel;
    logic        win_wr;
    logic        win_rd;
    logic        ram_sel;
    logic        ram_pending;
    logic        status_clear;
    logic [1:0]  hit;

    assign ofs     = indirect_address_pointer[10:0];
    assign ptr_sel = (dcr_addr_i == DCR_PTR_ADDR);
    assign win_sel = (dcr_addr_i == DCR_WIN_ADDR);
    assign win_wr  = win_sel && dcr_write_i;
    assign win_rd  = win_sel && dcr_read_i;
    assign ram_sel = (ofs >= OFS_RAM_FIRST);

    // Pointer register; written before any window access
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            indirect_address_pointer <= RESET_WORD;
        end
        else if (ptr_sel && dcr_write_i)
        begin
            indirect_address_pointer <= dcr_wdata_i;
        end
    end

    // Index origins and region definitions, reserved bits masked off
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_origin
            always_ff @(posedge mclk_i)
            begin
                if (sys_rst_i)
                begin
                    index_origin[gi] <= RESET_WORD;
                end
                else if (win_wr && ofs == OFS_ORIGIN_FIRST + 11'(gi))
                begin
                    index_origin[gi] <= dcr_wdata_i & ORIGIN_MASK;
                end
            end
        end
        for (gi = 0; gi < 2; gi++)
        begin : g_region
            always_ff @(posedge mclk_i)
            begin
                if (sys_rst_i)
                begin
                    region_decode[gi] <= RESET_WORD;
                end
                else if (win_wr && ofs == OFS_REGION_0 + 11'(gi))
                begin
                    region_decode[gi] <= dcr_wdata_i & REGION_MASK;
                end
            end
            dcr_cfg_region u_region (
                .mclk_i    (mclk_i),
                .sys_rst_i (sys_rst_i),
                .region_i  (region_decode[gi]),
                .addr_i    (fetch_addr_i),
                .hit_o     (hit[gi])
            );
        end
    endgenerate

    // Configuration; flush bit is never stored so it always reads 0
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            decompressor_configuration <= RESET_WORD;
        end
        else if (win_wr && ofs == OFS_CONFIG)
        begin
            decompressor_configuration <= dcr_wdata_i & CONFIG_MASK
                                          & ~(32'h1 << CFG_FLUSH_BIT);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            flush_output_buffer_o <= 1'b0;
        end
        else
        begin
            flush_output_buffer_o <= win_wr && ofs == OFS_CONFIG
                                     && dcr_wdata_i[CFG_FLUSH_BIT];
        end
    end

    // Error capture; a new capture wins over a read-clear in the same cycle
    assign status_clear = win_rd && ofs == OFS_ERR_STATUS;
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            sysbus_error_address  <= RESET_WORD;
            memside_error_address <= RESET_WORD;
            error_status          <= RESET_WORD;
        end
        else if (err_capture_i)
        begin
            sysbus_error_address  <= err_sys_addr_i;
            memside_error_address <= err_mem_addr_i;
            error_status          <= err_status_i;
        end
        else if (status_clear)
        begin
            error_status <= RESET_WORD;
        end
    end

    dcr_cfg_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (10)
    ) u_ram (
        .mclk_i  (mclk_i),
        .we_i    (win_wr && ram_sel),
        .addr_i  (ofs[9:0]),
        .wdata_i (dcr_wdata_i),
        .rdata_o (ram_rdata)
    );

    // Read mux; identity and version have no write path
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (ptr_sel)
        begin
            next_rdata = indirect_address_pointer;
        end
        else if (win_sel)
        begin
            case (ofs)
                11'h000, 11'h001, 11'h002, 11'h003:
                    next_rdata = index_origin[ofs[1:0]];
                OFS_REGION_0:     next_rdata = region_decode[0];
                OFS_REGION_1:     next_rdata = region_decode[1];
                OFS_CONFIG:       next_rdata = decompressor_configuration;
                OFS_IDENTITY:     next_rdata = IDENTITY;
                OFS_VERSION:      next_rdata = VERSION;
                OFS_SYS_ERR_ADDR: next_rdata = sysbus_error_address;
                OFS_MEM_ERR_ADDR: next_rdata = memside_error_address;
                OFS_ERR_STATUS:   next_rdata = error_status;
                default:          next_rdata = 32'h00000000;
            endcase
        end
    end

    // RAM reads need one extra cycle for the synchronous array
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            dcr_rdata_o <= 32'h00000000;
            dcr_ack_o   <= 1'b0;
            ram_pending <= 1'b0;
        end
        else
        begin
            ram_pending <= win_rd && ram_sel && !ram_pending;
            dcr_ack_o   <= ram_pending
                           || ((dcr_read_i || dcr_write_i) && !(win_rd && ram_sel));
            dcr_rdata_o <= ram_pending ? ram_rdata : next_rdata;
        end
    end

    // Control outputs derived from the stored configuration
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            index_origin_0_o    <= RESET_WORD;
            index_origin_1_o    <= RESET_WORD;
            index_origin_2_o    <= RESET_WORD;
            index_origin_3_o    <= RESET_WORD;
            region_hit_o        <= 2'b00;
            decompress_active_o <= 1'b0;
            sleep_allow_o       <= 1'b0;
            sleep_delay_count_o <= 10'h000;
        end
        else
        begin
            index_origin_0_o    <= index_origin[0];
            index_origin_1_o    <= index_origin[1];
            index_origin_2_o    <= index_origin[2];
            index_origin_3_o    <= index_origin[3];
            region_hit_o        <= hit;
            decompress_active_o <= compressed_page_attribute_i
                                   && !decompressor_configuration[CFG_DISABLE_BIT];
            sleep_allow_o       <= decompressor_configuration[CFG_SLEEP_EN_BIT];
            sleep_delay_count_o <= decompressor_configuration[CFG_DELAY_LSB +: 10];
        end
    end

    property p_flush_self_clear;
        @(posedge mclk_i) disable iff (sys_rst_i)
        flush_output_buffer_o |=> !flush_output_buffer_o || $past(win_wr);
    endproperty
    a_flush_self_clear: assert property (p_flush_self_clear)
        else $error("flush pulse stuck");

    property p_cfg_flush_reads_zero;
        @(posedge mclk_i) disable iff (sys_rst_i)
        !decompressor_configuration[CFG_FLUSH_BIT];
    endproperty
    a_cfg_flush_reads_zero: assert property (p_cfg_flush_reads_zero)
        else $error("flush bit stored");

    property p_disable_gate;
        @(posedge mclk_i) disable iff (sys_rst_i)
        decompressor_configuration[CFG_DISABLE_BIT] && $stable(decompressor_configuration)
        |=> !decompress_active_o;
    endproperty
    a_disable_gate: assert property (p_disable_gate)
        else $error("decompression active while disabled");

    property p_id_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        win_rd && ofs == OFS_IDENTITY |=> dcr_ack_o && dcr_rdata_o == IDENTITY;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identity read wrong");

    property p_status_clear;
        @(posedge mclk_i) disable iff (sys_rst_i)
        status_clear && !err_capture_i |=> error_status == 32'h00000000;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status not cleared");

    property p_origin_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (index_origin[0] & ~ORIGIN_MASK) == 32'h00000000;
    endproperty
    a_origin_reserved: assert property (p_origin_reserved)
        else $error("origin reserved bits set");

    property p_region_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (region_decode[1] & ~REGION_MASK) == 32'h00000000;
    endproperty
    a_region_reserved: assert property (p_region_reserved)
        else $error("region reserved bits set");

    property p_region_off;
        @(posedge mclk_i) disable iff (sys_rst_i)
        !region_decode[0][REG_EN_BIT] [*3] |-> !region_hit_o[0];
    endproperty
    a_region_off: assert property (p_region_off)
        else $error("hit on disabled region");

    property p_ram_ack;
        @(posedge mclk_i) disable iff (sys_rst_i)
        win_rd && ram_sel && !ram_pending |=> !dcr_ack_o ##1 dcr_ack_o;
    endproperty
    a_ram_ack: assert property (p_ram_ack)
        else $error("RAM read ack timing");

    property p_ptr_write;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ptr_sel && dcr_write_i |=> indirect_address_pointer == $past(dcr_wdata_i);
    endproperty
    a_ptr_write: assert property (p_ptr_write)
        else $error("pointer write lost");

    property p_size_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (region_decode[0][REG_SIZE_LSB +: 4] < SIZE_CODE_MIN) [*3] |-> !region_hit_o[0];
    endproperty
    a_size_reserved: assert property (p_size_reserved)
        else $error("hit on reserved size code");

    property p_unassigned_zero;
        @(posedge mclk_i) disable iff (sys_rst_i)
        win_rd && !ram_sel && ofs > OFS_ERR_STATUS
        |=> dcr_ack_o && dcr_rdata_o == 32'h00000000;
    endproperty
    a_unassigned_zero: assert property (p_unassigned_zero)
        else $error("unassigned offset read nonzero");

    c_ptr_write: cover property (@(posedge mclk_i) ptr_sel && dcr_write_i ##1 win_rd);
    c_ram_read: cover property (@(posedge mclk_i) win_rd && ram_sel ##2 dcr_ack_o);
    c_flush: cover property (@(posedge mclk_i) flush_output_buffer_o);
    c_status_clear: cover property (@(posedge mclk_i) status_clear && error_status != 32'h00000000);
endmodule : dcr_cfg_regs

// *** testbench/dcr_cfg_core.sv ***
// Processor core model driving the DCR pointer/window pair
module dcr_cfg_core import dcr_cfg_pkg::*; (
    input  wire logic        mclk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        ack_i,
    output logic      [9:0]  addr_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        addr_o  = 10'h000;
        read_o  = 1'b0;
        write_o = 1'b0;
        wdata_o = 32'h00000000;
    end

    // One access; RAM reads answer a cycle late, so the wait allows four cycles
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        @(posedge mclk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        read_o  = !wr;
        write_o = wr;
        @(posedge mclk_i);
        #1;
        read_o  = 1'b0;
        write_o = 1'b0;
        // Released lines show the inverse so stale values never pass for data
        addr_o  = ~a;
        wdata_o = ~d;
        n = 0;
        while (ack_i !== 1'b1 && n < 4)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        ok = (ack_i === 1'b1);
        q  = rdata_i;
    endtask : xfer

    // Pointer is always written before the window is touched
    task automatic ind_wr(input logic [10:0] o, input logic [31:0] d, output logic ok);
        logic [31:0] q;
        logic        ok1;
        xfer(1'b1, DCR_PTR_ADDR, {21'h0, o}, q, ok1);
        xfer(1'b1, DCR_WIN_ADDR, d, q, ok);
        ok = ok & ok1;
    endtask : ind_wr

    task automatic ind_rd(input logic [10:0] o, output logic [31:0] q, output logic ok);
        logic ok1;
        xfer(1'b1, DCR_PTR_ADDR, {21'h0, o}, q, ok1);
        xfer(1'b0, DCR_WIN_ADDR, 32'h00000000, q, ok);
        ok = ok & ok1;
    endtask : ind_rd
endmodule : dcr_cfg_core

// *** testbench/test_decompressor_config_regs.sv ***
// Self-checking bench for the decompressor configuration register bank
module test_decompressor_config_regs import dcr_cfg_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    // Arbitrary identity values handed to the design
    localparam logic [31:0] ID_VAL  = 32'h0000ABCD;
    localparam logic [31:0] VER_VAL = 32'h00000007;

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [9:0]  dcr_addr;
    logic        dcr_read, dcr_write, page_attr = 1'b0, err_cap = 1'b0;
    logic [31:0] dcr_wdata, dcr_rdata, fetch_addr = 32'h0;
    logic [31:0] err_sys = 32'h0, err_mem = 32'h0, err_stat = 32'h0;
    logic        dcr_ack, active, flush, sl_allow;
    logic [31:0] org0, org1, org2, org3;
    logic [31:0] org [4];
    logic [1:0]  hit;
    logic [9:0]  sl_delay;
    int          fails = 0, cmp_count = 0, flush_seen = 0, cycles = 0;

    always #5 mclk = ~mclk;

    dcr_cfg_regs #(.IDENTITY(ID_VAL), .VERSION(VER_VAL)) dut (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .dcr_addr_i(dcr_addr), .dcr_read_i(dcr_read),
        .dcr_write_i(dcr_write), .dcr_wdata_i(dcr_wdata), .dcr_rdata_o(dcr_rdata),
        .dcr_ack_o(dcr_ack), .fetch_addr_i(fetch_addr), .compressed_page_attribute_i(page_attr),
        .err_capture_i(err_cap), .err_sys_addr_i(err_sys), .err_mem_addr_i(err_mem),
        .err_status_i(err_stat), .index_origin_0_o(org0), .index_origin_1_o(org1),
        .index_origin_2_o(org2), .index_origin_3_o(org3), .region_hit_o(hit),
        .decompress_active_o(active), .flush_output_buffer_o(flush),
        .sleep_allow_o(sl_allow), .sleep_delay_count_o(sl_delay));

    // Array view of the origin outputs so the checks can loop over them
    always_comb
    begin
        org[0] = org0;
        org[1] = org1;
        org[2] = org2;
        org[3] = org3;
    end

    dcr_cfg_core core (.mclk_i(mclk), .rdata_i(dcr_rdata), .ack_i(dcr_ack), .addr_o(dcr_addr),
        .read_o(dcr_read), .write_o(dcr_write), .wdata_o(dcr_wdata));

    task automatic end_of_test;
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // Whole run needs under 250 cycles; a hang is cut off well beyond that
    always @(posedge mclk)
    begin
        cycles++;
        if (flush === 1'b1)
            flush_seen++;
        if (cycles == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [10:0] o, input logic [31:0] d);
        logic ok;
        core.ind_wr(o, d, ok);
        check({31'h0, ok}, 32'h1);
    endtask : wr

    task automatic rd(input logic [10:0] o, input logic [31:0] e);
        logic        ok;
        logic [31:0] q;
        core.ind_rd(o, q, ok);
        check({31'h0, ok}, 32'h1);
        check(q, e);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic t_reset;
        for (int i = 0; i < 6; i++)
            rd(i[10:0], 32'h0);
        rd(OFS_CONFIG, 32'h0);
        wr(OFS_IDENTITY, 32'hFFFFFFFF);
        wr(OFS_VERSION, 32'h00000000);
        rd(OFS_IDENTITY, ID_VAL);
        rd(OFS_VERSION, VER_VAL);
    endtask : t_reset

    task automatic t_origin;
        for (int i = 0; i < 4; i++)
            wr(i[10:0], {21'h1FFFFF, i[1:0], 9'h0A5});
        for (int i = 0; i < 4; i++)
        begin
            rd(i[10:0], {21'h0, i[1:0], 9'h0A5});
            check(org[i], {21'h0, i[1:0], 9'h0A5});
        end
    endtask : t_origin

    task automatic t_hit(input logic [10:0] o, input logic [31:0] v, input logic [31:0] a,
                         input logic [1:0] e);
        wr(o, v);
        fetch_addr = a;
        settle();
        check({30'h0, hit}, {30'h0, e});
    endtask : t_hit

    task automatic t_region;
        wr(OFS_REGION_0, 32'hFFFFFFFF);
        rd(OFS_REGION_0, REGION_MASK);
        t_hit(OFS_REGION_0, 32'h00450001, 32'h007FFFFC, 2'b01);
        t_hit(OFS_REGION_0, 32'h00450001, 32'h00800000, 2'b00);
        t_hit(OFS_REGION_0, 32'h00060001, 32'h007FFFFC, 2'b01);
        t_hit(OFS_REGION_0, 32'h00450000, 32'h00400000, 2'b00);
        t_hit(OFS_REGION_0, 32'h00440001, 32'h00400000, 2'b00);
        t_hit(OFS_REGION_1, 32'h000F0001, 32'hFFFFFFFC, 2'b10);
        t_hit(OFS_REGION_0, 32'h00450001, 32'h00400000, 2'b11);
        t_hit(OFS_REGION_1, 32'h00000000, 32'h00400000, 2'b01);
    endtask : t_region

    task automatic t_config;
        int f0;
        f0 = flush_seen;
        page_attr = 1'b1;
        wr(OFS_CONFIG, 32'h00003FFC);
        rd(OFS_CONFIG, 32'h00003FF8);
        check(flush_seen - f0, 32'h1);
        check({22'h0, sl_delay, sl_allow, active}, 32'h00000FFF);
        wr(OFS_CONFIG, 32'hFFFFFFFF);
        rd(OFS_CONFIG, 32'h00003FF9);
        settle();
        check({31'h0, active}, 32'h0);
        wr(OFS_CONFIG, 32'h00000010);
        page_attr = 1'b0;
        settle();
        check(flush_seen - f0, 32'h2);
        check({22'h0, sl_delay, sl_allow, active}, 32'h00000004);
    endtask : t_config

    task automatic t_error;
        err_sys  = 32'h13572468;
        err_mem  = 32'h8642ACE0;
        err_stat = 32'hC0000000;
        err_cap  = 1'b1;
        @(posedge mclk);
        #1;
        err_cap  = 1'b0;
        err_sys  = 32'h0;
        err_mem  = 32'h0;
        err_stat = 32'h0;
        wr(OFS_SYS_ERR_ADDR, 32'h00000000);
        rd(OFS_SYS_ERR_ADDR, 32'h13572468);
        rd(OFS_MEM_ERR_ADDR, 32'h8642ACE0);
        rd(OFS_ERR_STATUS, 32'hC0000000);
        rd(OFS_ERR_STATUS, 32'h00000000);
    endtask : t_error

    task automatic t_edge;
        logic [31:0] q;
        logic        ok;
        wr(11'h006, 32'hFFFFFFFF);
        rd(11'h006, 32'h0);
        rd(11'h043, 32'h0);
        rd(11'h3FF, 32'h0);
        core.xfer(1'b1, 10'h016, 32'hFFFFFFFF, q, ok);
        check({31'h0, ok}, 32'h1);
        core.xfer(1'b0, 10'h013, 32'h0, q, ok);
        check(q, 32'h0);
        core.xfer(1'b1, DCR_PTR_ADDR, 32'hFFFFF841, q, ok);
        core.xfer(1'b0, DCR_PTR_ADDR, 32'h0, q, ok);
        check(q, 32'hFFFFF841);
        core.xfer(1'b0, DCR_WIN_ADDR, 32'h0, q, ok);
        check(q, ID_VAL);
        wr(11'h400, 32'hA1B2C3D4);
        wr(11'h7FF, 32'h5E6F7081);
        rd(11'h400, 32'hA1B2C3D4);
        rd(11'h7FF, 32'h5E6F7081);
    endtask : t_edge

    initial
    begin
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_origin();
        t_region();
        t_config();
        t_error();
        t_edge();
        end_of_test();
    end
endmodule : test_decompressor_config_regs
